// >>> src/ub_uart.sv
// Contract
// - Three address bits per port, two ports.
// - Divisor select maps offsets 0,1 to divisor.
// - Offset 0 read returns received byte.
// - Serial bits travel least significant first.
// - Shift register assembles byte, then holding register.
// - Offset 0 write loads transmit holding register.
// - Transmit shifter reloads only after finishing.
// - All enables clear: no interrupt reported.
// - Enable bit 0: data available and timeout.
// - Enable bit 1: transmit holding empty.
// - Enable bit 2: receiver line status errors.
// - Enable bit 3: modem status changes.
// - Enable bits 7:4 always read zero.
// - Offset 2: fifo setup write, source read.
// - Setup bit 0 enables; clearing empties queues.
// - Setup bits 1,2 flush queues, self-clear.
// - Setup bit 3 and bits 5:4 ignored.
// - Setup bits 7:6 pick trigger 1/4/8/14.
// - Priority: line, data, transmit, modem.
// - Source value frozen during the read.
// - Source bit 0 low means pending.
// - Source bits 3:1 code; 5:4 zero.
// - Source bits 7:6 set in queue mode.
// - Timeout after four idle character times.
// - Source codes and their clearing events.
// - Interrupt driven only while aux output two.
//
// Implementation choice: register access over AXI4-Lite.
`include "ub_regs.svh"

module ub_uart #(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire ub_pkg::ub_axi_req_t axi_req,
  output      ub_pkg::ub_axi_rsp_t axi_rsp,
  input  wire logic [1:0]          rxd,
  input  wire ub_pkg::ub_modem_t   modem_in [2],
  output      logic [1:0]          txd,
  output      logic [1:0]          irq,
  output      logic [1:0]          irq_oe
);
  import ub_pkg::*;

  localparam ub_port_t  PORT_RST = '{txd: 1'b1, txo: 1'b1, default: '0};
  localparam ub_state_t STATE_RST = '{p: {PORT_RST, PORT_RST}, default: '0};

  ub_state_t s;
  ub_state_t nxt_s;

  // Bus decode results shared by the update logic and the checks.
  logic        do_wr;
  logic        do_rd;
  logic        wr_ok;
  logic        rd_ok;
  logic        w_port;
  logic        r_port;
  logic [2:0]  w_idx;
  logic [2:0]  r_idx;
  logic [7:0]  w_dat;
  logic [31:0] w_off;
  logic [31:0] r_off;
  logic [31:0] w_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt source value of one port, built from its current state.
  function automatic logic [7:0] src_of(ub_port_t p);
    logic       ls;
    logic       rda;
    logic       tmo;
    logic       th;
    logic       ms;
    logic [4:0] lvl;
    logic [3:0] code;
    unique case (p.trig)
      2'd0: lvl = `UB_TRIG_L0;
      2'd1: lvl = `UB_TRIG_L1;
      2'd2: lvl = `UB_TRIG_L2;
      2'd3: lvl = `UB_TRIG_L3;
    endcase
    if (!p.fifo_en) begin
      lvl = `UB_TRIG_L0;
    end
    ls   = p.interrupt_enable[`UB_IER_RLS] & (p.oe | p.fe | p.bi);
    rda  = p.interrupt_enable[`UB_IER_RDA] & (p.rx_cnt >= lvl);
    tmo  = p.interrupt_enable[`UB_IER_RDA] & p.fifo_en & (p.rx_cnt != 5'd0) & (p.to_cnt == `UB_TO_TICKS);
    th   = p.interrupt_enable[`UB_IER_THRE] & p.thre_int;
    ms   = p.interrupt_enable[`UB_IER_MS] & (|p.msr_delta);
    // Highest pending source wins; nothing pending reads as code one.
    if (ls) begin
      code = `UB_IIR_RLS;
    end else if (rda) begin
      code = `UB_IIR_RDA;
    end else if (tmo) begin
      code = `UB_IIR_TO;
    end else if (th) begin
      code = `UB_IIR_THRE;
    end else if (ms) begin
      code = `UB_IIR_MS;
    end else begin
      code = `UB_IIR_NONE;
    end
    return {{2{p.fifo_en}}, 2'b00, code};
  endfunction : src_of

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, then each port in turn.
  always_comb begin
    ub_port_t   pt;
    ub_port_t   np;
    logic       wr_me;
    logic       rd_me;
    logic       divisor_latch_select;
    logic [4:0] cap;
    logic [15:0] div;
    logic       tx_push;
    logic       tx_pop;
    logic       rx_push;
    logic       rx_pop;
    logic       tx_flush;
    logic       rx_flush;
    logic       ier1_rise;
    logic [7:0] src;
    logic [7:0] src_nxt;
    logic [7:0] rv;
    logic [7:0] rv_all;
    pt = '0;
    np = '0;
    wr_me = 1'b0;
    rd_me = 1'b0;
    divisor_latch_select = 1'b0;
    cap = '0;
    div = '0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_flush = 1'b0;
    rx_flush = 1'b0;
    ier1_rise = 1'b0;
    src = '0;
    src_nxt = '0;
    rv = '0;
    rv_all = '0;
    nxt_s = s;

    // Write channels are taken in either order and joined before the update.
    if (axi_req.awvalid && s.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.wready) begin
      nxt_s.w_got  = 1'b1;
      nxt_s.wdata  = axi_req.wdata[7:0];
      nxt_s.wstrb0 = axi_req.wstrb[0];
    end
    w_addr = nxt_s.awaddr;
    w_off  = w_addr - BASE_ADDR;
    r_off  = axi_req.araddr - BASE_ADDR;
    do_wr  = nxt_s.aw_got && nxt_s.w_got && !s.bvalid;
    wr_ok  = (w_off < `UB_MAP_BYTES);
    w_port = w_off[`UB_PORT_BIT];
    w_idx  = w_off[4:2];
    w_dat  = nxt_s.wstrb0 ? nxt_s.wdata : 8'h00;
    do_rd  = axi_req.arvalid && s.arready;
    rd_ok  = (r_off < `UB_MAP_BYTES);
    r_port = r_off[`UB_PORT_BIT];
    r_idx  = r_off[4:2];
    if (do_wr) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = wr_ok ? `UB_RESP_OKAY : `UB_RESP_SLVERR;
    end else if (s.bvalid && axi_req.bready) begin
      nxt_s.bvalid = 1'b0;
    end

    for (int i = 0; i < 2; i++) begin
      pt = s.p[i];
      np = pt;
      wr_me = do_wr && wr_ok && nxt_s.wstrb0 && (w_port == 1'(i));
      rd_me = do_rd && rd_ok && (r_port == 1'(i));
      divisor_latch_select = pt.lcr[`UB_LCR_DIVISOR_LATCH_SELECT];
      cap = pt.fifo_en ? `UB_DEPTH : 5'd1;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      tx_flush = 1'b0;
      rx_flush = 1'b0;
      ier1_rise = 1'b0;
      src = src_of(pt);

      // Oversampling enable from the divisor; zero behaves as one.
      div = {pt.dlm, pt.dll};
      np.tick = (pt.baud_cnt == 16'h0000);
      np.baud_cnt = np.tick ? ((div == 16'h0000) ? 16'h0000 : div - 16'h0001) : pt.baud_cnt - 16'h0001;

      // Transmitter: start bit, eight data bits from bit 0, one stop bit.
      if (pt.tick) begin
        if (pt.tx_busy) begin
          np.tx_sub = pt.tx_sub + 4'h1;
          if (pt.tx_sub == 4'hf) begin
            np.txd = pt.tx_sh[0];
            np.tx_sh = {1'b1, pt.tx_sh[8:1]};
            np.tx_bit = pt.tx_bit + 4'h1;
            if (pt.tx_bit == 4'h9) begin
              np.tx_busy = 1'b0;
              np.txd = 1'b1;
            end
          end
        end else if (pt.tx_cnt != 5'd0) begin
          tx_pop = 1'b1;
          np.tx_busy = 1'b1;
          np.txd = 1'b0;
          np.tx_sh = {1'b1, pt.txq[pt.tx_rp]};
          np.tx_bit = 4'h0;
          np.tx_sub = 4'h0;
        end
      end

      // Receiver: sample each bit at mid-cell, shift in from the top.
      if (pt.tick) begin
        if (!pt.rx_busy) begin
          if (!rxd[i]) begin
            np.rx_busy = 1'b1;
            np.rx_sub = 4'h0;
            np.rx_bit = 4'h0;
          end
        end else begin
          np.rx_sub = pt.rx_sub + 4'h1;
          if (pt.rx_sub == 4'h7) begin
            np.rx_bit = pt.rx_bit + 4'h1;
            if (pt.rx_bit == 4'h0) begin
              np.rx_busy = !rxd[i];
            end else if (pt.rx_bit < 4'h9) begin
              np.rx_sh = {rxd[i], pt.rx_sh[7:1]};
            end else begin
              np.rx_busy = 1'b0;
              np.fe = pt.fe | !rxd[i];
              np.bi = pt.bi | (!rxd[i] && pt.rx_sh == 8'h00);
              if (pt.rx_cnt < cap) begin
                rx_push = 1'b1;
              end else begin
                np.oe = 1'b1;
              end
            end
          end
        end
      end

      // Register writes.
      if (wr_me) begin
        unique case (w_idx)
          `UB_IDX_DATA: begin
            if (divisor_latch_select) begin
              np.dll = w_dat;
            end else if (pt.tx_cnt < cap) begin
              tx_push = 1'b1;
            end
          end
          `UB_IDX_IER: begin
            if (divisor_latch_select) begin
              np.dlm = w_dat;
            end else begin
              np.interrupt_enable = w_dat[3:0];
              ier1_rise = w_dat[`UB_IER_THRE] && !pt.interrupt_enable[`UB_IER_THRE];
            end
          end
          `UB_IDX_IIR: begin
            // Bit 3 and bits 5:4 have no function.
            if (w_dat[`UB_FCR_EN]) begin
              np.fifo_en = 1'b1;
              np.trig = w_dat[7:6];
              rx_flush = w_dat[`UB_FCR_RXCLR] || !pt.fifo_en;
              tx_flush = w_dat[`UB_FCR_TXCLR] || !pt.fifo_en;
            end else begin
              np.fifo_en = 1'b0;
              rx_flush = 1'b1;
              tx_flush = 1'b1;
            end
          end
          `UB_IDX_LCR: np.lcr = w_dat;
          `UB_IDX_MCR: np.mcr = w_dat;
          `UB_IDX_SCR: np.scr = w_dat;
          default: ;
        endcase
      end

      // Register reads and their side effects.
      rv = 8'h00;
      if (rd_me) begin
        unique case (r_idx)
          `UB_IDX_DATA: begin
            if (divisor_latch_select) begin
              rv = pt.dll;
            end else begin
              rv = pt.rxq[pt.rx_rp];
              rx_pop = (pt.rx_cnt != 5'd0);
            end
          end
          `UB_IDX_IER: rv = divisor_latch_select ? pt.dlm : {4'h0, pt.interrupt_enable};
          `UB_IDX_IIR: rv = src;
          `UB_IDX_LCR: rv = pt.lcr;
          `UB_IDX_MCR: rv = pt.mcr;
          `UB_IDX_LSR: begin
            rv = {1'b0, (pt.tx_cnt == 5'd0) && !pt.tx_busy, pt.tx_cnt == 5'd0, pt.bi, pt.fe, 1'b0, pt.oe,
                  pt.rx_cnt != 5'd0};
            np.oe = 1'b0;
            np.fe = 1'b0;
            np.bi = 1'b0;
          end
          `UB_IDX_MSR: begin
            rv = {pt.msr_prev, pt.msr_delta};
            np.msr_delta = 4'h0;
          end
          `UB_IDX_SCR: rv = pt.scr;
        endcase
      end
      rv_all = rv_all | rv;

      // Errors caught this cycle survive a clear made in the same cycle.
      if (pt.tick && pt.rx_busy && pt.rx_sub == 4'h7 && pt.rx_bit == 4'h9) begin
        np.fe = np.fe | !rxd[i];
        np.oe = np.oe | (pt.rx_cnt >= cap);
        np.bi = np.bi | (!rxd[i] && pt.rx_sh == 8'h00);
      end

      // Queue pointers and counts; a flush zeroes the counter logic only.
      if (tx_flush) begin
        np.tx_wp = 4'h0;
        np.tx_rp = 4'h0;
        np.tx_cnt = 5'd0;
      end else begin
        if (tx_push) begin
          np.txq[pt.tx_wp] = w_dat;
          np.tx_wp = pt.tx_wp + 4'h1;
        end
        if (tx_pop) begin
          np.tx_rp = pt.tx_rp + 4'h1;
        end
        np.tx_cnt = pt.tx_cnt + 5'(tx_push) - 5'(tx_pop);
      end
      if (rx_flush) begin
        np.rx_wp = 4'h0;
        np.rx_rp = 4'h0;
        np.rx_cnt = 5'd0;
      end else begin
        if (rx_push) begin
          np.rxq[pt.rx_wp] = pt.rx_sh;
          np.rx_wp = pt.rx_wp + 4'h1;
        end
        if (rx_pop) begin
          np.rx_rp = pt.rx_rp + 4'h1;
        end
        np.rx_cnt = pt.rx_cnt + 5'(rx_push) - 5'(rx_pop);
      end

      // Transmit-empty flag: cleared first, so a new empty event wins.
      if (tx_push || (rd_me && r_idx == `UB_IDX_IIR && src[3:0] == `UB_IIR_THRE)) begin
        np.thre_int = 1'b0;
      end
      if (np.tx_cnt == 5'd0 && (pt.tx_cnt != 5'd0 || ier1_rise || tx_flush)) begin
        np.thre_int = 1'b1;
      end

      // Idle timer for the character timeout; reset by any receive queue activity.
      if (!np.fifo_en || rx_push || rx_pop || np.rx_cnt == 5'd0) begin
        np.to_cnt = 10'd0;
      end else if (pt.tick && pt.to_cnt != `UB_TO_TICKS) begin
        np.to_cnt = pt.to_cnt + 10'd1;
      end

      // Modem change flags; a change in the read cycle is kept.
      np.msr_prev = modem_in[i];
      np.msr_delta = np.msr_delta | (modem_in[i] ^ pt.msr_prev);

      // Line output and gated interrupt request.
      np.txo = np.txd & !np.lcr[`UB_LCR_BREAK];
      // The request follows the source value that the register will hold next.
      src_nxt = src_of(np);
      np.irq = np.mcr[`UB_MCR_AUX2] & !src_nxt[0];
      nxt_s.p[i] = np;
    end

    // Read channel: one read at a time, answered the cycle after acceptance.
    if (do_rd) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = {24'h000000, rv_all};
      nxt_s.rresp = rd_ok ? `UB_RESP_OKAY : `UB_RESP_SLVERR;
    end else if (s.rvalid && axi_req.rready) begin
      nxt_s.rvalid = 1'b0;
    end
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
    nxt_s.arready = !nxt_s.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= STATE_RST;
    end else begin
      s <= nxt_s;
    end
  end

  // Outputs straight from the state register.
  assign axi_rsp = '{awready: s.awready, wready: s.wready, bvalid: s.bvalid, bresp: s.bresp,
                     arready: s.arready, rvalid: s.rvalid, rdata: s.rdata, rresp: s.rresp};
  for (genvar g = 0; g < 2; g++) begin : g_pins
    assign txd[g]    = s.p[g].txo;
    assign irq[g]    = s.p[g].irq;
    assign irq_oe[g] = s.p[g].mcr[`UB_MCR_AUX2];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on port 0.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence seq_wr0(logic [2:0] idx);
    do_wr && wr_ok && nxt_s.wstrb0 && !w_port && w_idx == idx;
  endsequence
  sequence seq_rd0(logic [2:0] idx);
    do_rd && rd_ok && !r_port && r_idx == idx;
  endsequence

  chk_irq_aux_gate: assert property (s.p[0].irq |-> s.p[0].mcr[`UB_MCR_AUX2] && irq_oe[0])
    else $error("interrupt raised with aux output two low");
  chk_all_off_quiet: assert property (s.p[0].interrupt_enable == 4'h0 |-> !irq[0])
    else $error("interrupt raised with all enables clear");
  chk_ier_top_zero: assert property (seq_rd0(`UB_IDX_IER) ##0 !s.p[0].lcr[`UB_LCR_DIVISOR_LATCH_SELECT] |=>
                                     axi_rsp.rvalid && axi_rsp.rdata[7:4] == 4'h0)
    else $error("enable register upper bits not zero");
  chk_src_mode_bits: assert property (seq_rd0(`UB_IDX_IIR) |=>
                                      axi_rsp.rdata[7:4] == {{2{$past(s.p[0].fifo_en)}}, 2'b00})
    else $error("source register mode bits wrong");
  chk_rx_flush_cnt: assert property (seq_wr0(`UB_IDX_IIR) ##0 (w_dat[1:0] == 2'b11) |=> s.p[0].rx_cnt == 5'd0)
    else $error("receive queue not emptied by flush");
  chk_fifo_off_empty: assert property (seq_wr0(`UB_IDX_IIR) ##0 !w_dat[0] |=>
                                       !s.p[0].fifo_en && s.p[0].rx_cnt == 5'd0 && s.p[0].tx_cnt == 5'd0)
    else $error("queues not emptied when disabled");
  chk_tx_hold_busy: assert property (s.p[0].tx_busy && !(do_wr && !w_port && w_idx == `UB_IDX_IIR) |=>
                                     $stable(s.p[0].tx_rp))
    else $error("transmit shifter reloaded while busy");
  chk_div_low_write: assert property (seq_wr0(`UB_IDX_DATA) ##0 s.p[0].lcr[7] |=>
                                      s.p[0].dll == $past(w_dat) && s.p[0].tx_wp == $past(s.p[0].tx_wp))
    else $error("divisor write reached the transmit queue");
  chk_thr_load: assert property (seq_wr0(`UB_IDX_DATA) ##0 (!s.p[0].lcr[7] && s.p[0].tx_cnt == 5'd0) |=>
                                 s.p[0].tx_cnt == 5'd1 || s.p[0].tx_busy)
    else $error("transmit holding write lost");

endmodule : ub_uart

// >>> src/ub_regs.svh
`ifndef UB_REGS_SVH
`define UB_REGS_SVH

// Register indices inside one port; the byte address is four times the index.
`define UB_IDX_DATA   3'd0
`define UB_IDX_IER    3'd1
`define UB_IDX_IIR    3'd2
`define UB_IDX_LCR    3'd3
`define UB_IDX_MCR    3'd4
`define UB_IDX_LSR    3'd5
`define UB_IDX_MSR    3'd6
`define UB_IDX_SCR    3'd7

// Address layout: word index in bits 4:2, port select in bit 5, two ports.
`define UB_PORT_BIT   5
`define UB_MAP_BYTES  32'h0000_0040

// Field positions.
`define UB_LCR_DIVISOR_LATCH_SELECT   7
`define UB_LCR_BREAK  6
`define UB_MCR_AUX2   3
`define UB_FCR_EN     0
`define UB_FCR_RXCLR  1
`define UB_FCR_TXCLR  2
`define UB_IER_RDA    0
`define UB_IER_THRE   1
`define UB_IER_RLS    2
`define UB_IER_MS     3

// Interrupt source codes in bits 3:0 of the identification register.
`define UB_IIR_NONE   4'h1
`define UB_IIR_RLS    4'h6
`define UB_IIR_RDA    4'h4
`define UB_IIR_TO     4'hc
`define UB_IIR_THRE   4'h2
`define UB_IIR_MS     4'h0

// Receive trigger levels in bytes.
`define UB_TRIG_L0    5'd1
`define UB_TRIG_L1    5'd4
`define UB_TRIG_L2    5'd8
`define UB_TRIG_L3    5'd14

// Queue depth, oversampling and character timeout.
`define UB_DEPTH      5'd16
`define UB_OVERSAMPLE 16
`define UB_TO_CHARS   4
`define UB_CHAR_BITS  10
`define UB_TO_TICKS   10'(`UB_TO_CHARS * `UB_CHAR_BITS * `UB_OVERSAMPLE)

// Bus responses.
`define UB_RESP_OKAY   2'b00
`define UB_RESP_SLVERR 2'b10

`endif

// >>> src/ub_pkg.sv
package ub_pkg;

  // Master to slave signals of the register bus.
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } ub_axi_req_t;

  // Slave to master signals of the register bus.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ub_axi_rsp_t;

  // Modem status inputs of one port, active high.
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ub_modem_t;

  // Complete state of one serial port.
  typedef struct packed {
    logic [3:0]       interrupt_enable;
    logic [7:0]       lcr;
    logic [7:0]       mcr;
    logic [7:0]       dll;
    logic [7:0]       dlm;
    logic [7:0]       scr;
    logic             fifo_en;
    logic [1:0]       trig;
    logic [15:0][7:0] txq;
    logic [3:0]       tx_wp;
    logic [3:0]       tx_rp;
    logic [4:0]       tx_cnt;
    logic [15:0][7:0] rxq;
    logic [3:0]       rx_wp;
    logic [3:0]       rx_rp;
    logic [4:0]       rx_cnt;
    logic [15:0]      baud_cnt;
    logic             tick;
    logic             tx_busy;
    logic [8:0]       tx_sh;
    logic [3:0]       tx_bit;
    logic [3:0]       tx_sub;
    logic             txd;
    logic             txo;
    logic             rx_busy;
    logic [7:0]       rx_sh;
    logic [3:0]       rx_bit;
    logic [3:0]       rx_sub;
    logic             oe;
    logic             fe;
    logic             bi;
    logic             thre_int;
    logic [9:0]       to_cnt;
    logic [3:0]       msr_prev;
    logic [3:0]       msr_delta;
    logic             irq;
  } ub_port_t;

  // Complete state of the block.
  typedef struct packed {
    ub_port_t [1:0] p;
    logic           aw_got;
    logic [31:0]    awaddr;
    logic           w_got;
    logic [7:0]     wdata;
    logic           wstrb0;
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } ub_state_t;

endpackage : ub_pkg

// >>> tb/ub_line_model.sv
////////////////////////////////////////////////////////////////////////////////
// Remote serial equipment: sends frames into the port and captures its frames.
module ub_line_model (
  input  wire logic       clk_sys,
  input  wire logic       txd,
  output      logic       rxd,
  output      logic [7:0] got,
  output      logic       got_v
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sixteen clocks per bit with a divisor of one.
  localparam int BIT_CLKS = 16;

  // The line idles at the mark level.
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    got_v = 1'b0;
  end

  // Sends start bit, eight data bits least significant first, stop bit.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      rxd <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i-1]);
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  endtask : send_byte

  // Captures each frame in mid-bit and toggles got_v when it is complete.
  always begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_sys);
      got[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk_sys);
    got_v = ~got_v;
  end
endmodule : ub_line_model

// >>> tb/uart_buffer_irq_regs_tb.sv
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the serial port register front end.
module uart_buffer_irq_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ub_pkg::*;
  localparam logic [31:0] BASE = 32'h0000_0100;

  logic              clk_sys;
  logic              nrst;
  ub_axi_req_t       req;
  ub_axi_rsp_t       rsp;
  ub_modem_t         modem [2];
  logic              line_rxd;
  logic [1:0]        txd;
  logic [1:0]        irq;
  logic [1:0]        irq_oe;
  logic [7:0]        got;
  logic              got_v;
  logic [31:0]       d;
  logic [1:0]        rs;
  logic              old_v;
  int                mismatches;
  int                total_checks;
  int                wt;
  // Row: bit 11 write, bits 10:8 index, bits 7:0 data or expected read value.
  logic [11:0]       rows [16] = '{
    12'h100, 12'h201, 12'h9f0, 12'h100,
    12'hb80, 12'h801, 12'h900, 12'h001, 12'h100, 12'hb03,
    12'hac7, 12'h2c1, 12'h902, 12'h2c2, 12'h2c1, 12'hc08
  };

  ub_uart #(.BASE_ADDR(BASE)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
    .rxd({1'b1, line_rxd}), .modem_in(modem), .txd(txd), .irq(irq), .irq_oe(irq_oe));
  ub_line_model line_u (.clk_sys(clk_sys), .txd(txd[0]), .rxd(line_rxd), .got(got), .got_v(got_v));

  // Free running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Ends the run when a wait has used up its bound.
  task automatic give_up(input int n);
    if (n >= 2000) begin
      mismatches++;
      test_done();
    end
  endtask : give_up

  // Write: address and data offered together, each released when taken.
  task automatic wr(input logic [4:0] idx, input logic [7:0] v);
    int n;
    req.awvalid <= 1'b1;
    req.awaddr <= BASE + 32'(idx) * 4;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_sys);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    give_up(n);
  endtask : wr

  // Read: data and response taken at the edge where rvalid is high.
  task automatic rd(input logic [4:0] idx, output logic [31:0] v, output logic [1:0] r);
    int n;
    req.arvalid <= 1'b1;
    req.araddr <= BASE + 32'(idx) * 4;
    req.rready <= 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_sys);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    v = rsp.rdata;
    r = rsp.rresp;
    give_up(n);
  endtask : rd

  // Main sequence: reset, table rows, then hand-written cases.
  initial begin
    mismatches = 0;
    total_checks = 0;
    req = '0;
    modem[0] = '0;
    modem[1] = '0;
    nrst = 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk(txd, 2'b11);
    foreach (rows[i]) begin
      if (rows[i][11]) wr({2'b0, rows[i][10:8]}, rows[i][7:0]);
      else begin
        rd({2'b0, rows[i][10:8]}, d, rs);
        chk(d, {24'h0, rows[i][7:0]});
      end
    end
    // Transmit one byte and let the partner capture it.
    old_v = got_v;
    wr(5'd0, 8'ha5);
    for (wt = 0; wt < 2000 && got_v === old_v; wt++) @(posedge clk_sys);
    give_up(wt);
    chk(got, 8'ha5);
    chk(irq[0], 1'b1);
    rd(5'd2, d, rs);
    chk(d, 32'hc2);
    wr(5'd4, 8'h00);
    chk(irq_oe[0], 1'b0);
    // Received byte with trigger level one.
    wr(5'd2, 8'h01);
    wr(5'd1, 8'h01);
    line_u.send_byte(8'h3c);
    repeat (20) @(posedge clk_sys);
    rd(5'd2, d, rs);
    chk(d, 32'hc4);
    rd(5'd0, d, rs);
    chk(d, 32'h3c);
    // One byte below trigger fourteen raises the timeout after four characters.
    wr(5'd2, 8'hc1);
    line_u.send_byte(8'h96);
    repeat (200) @(posedge clk_sys);
    rd(5'd2, d, rs);
    chk(d, 32'hc1);
    repeat (700) @(posedge clk_sys);
    rd(5'd2, d, rs);
    chk(d, 32'hcc);
    rd(5'd0, d, rs);
    chk(d, 32'h96);
    // Modem line change with only the modem enable set.
    wr(5'd1, 8'h08);
    modem[0].cts <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(5'd2, d, rs);
    chk(d, 32'hc0);
    // Leaving queue mode clears bits 7:6; the modem change stays pending until read.
    wr(5'd2, 8'h00);
    rd(5'd2, d, rs);
    chk(d, 32'h00);
    rd(5'd6, d, rs);
    chk(d, 32'h11);
    rd(5'd2, d, rs);
    chk(d, 32'h01);
    // The second port holds its own register set.
    wr(5'd9, 8'h0f);
    rd(5'd9, d, rs);
    chk(d, 32'h0f);
    rd(5'd1, d, rs);
    chk(d, 32'h08);
    rd(5'd10, d, rs);
    chk(d, 32'h02);
    // Unmapped address answers with an error.
    rd(5'd16, d, rs);
    chk({30'h0, rs}, 32'h2);
    chk(d, 32'h0);
    test_done();
  end
endmodule : uart_buffer_irq_regs_tb
